// ==== src/acm_pkg.sv ====
// Package of register map, field positions and reset values for the counter/mask/control bank
package acm_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_CNT_LOW   = 8'h04;
    localparam logic [7:0] OFF_CNT_HIGH  = 8'h05;
    localparam logic [7:0] OFF_CNT_SEL   = 8'h06;
    localparam logic [7:0] OFF_INT_MASK  = 8'h07;
    localparam logic [7:0] OFF_EXT_CTRL  = 8'h08;
    localparam logic [7:0] OFF_INT_STAT  = 8'h01;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int SEL_HEC_ERR   = 0;
    localparam int SEL_RX_CELL   = 1;
    localparam int SEL_TX_CELL   = 2;
    localparam int SEL_SYM_ERR   = 3;
    localparam int SEL_WIDTH     = 4;
    localparam int SRC_RX_OVF    = 0;
    localparam int SRC_SYM_ERR   = 1;
    localparam int SRC_SIG_CHG   = 2;
    localparam int SRC_TX_PAR    = 3;
    localparam int SRC_SHORT     = 4;
    localparam int SRC_HEC_CELL  = 5;
    localparam int SRC_WIDTH     = 6;
    localparam int CTRL_SW_RESET = 7;
    localparam int CTRL_LOOP_CLK = 6;
    localparam int CTRL_RSVD5    = 5;
    localparam int PORT_ADDR_LSB = 0;
    localparam int PORT_ADDR_W   = 5;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_CNT_SEL  = 8'h00;
    localparam logic [7:0] RST_INT_MASK = 8'h00;
    localparam logic [7:0] RST_EXT_CTRL = 8'h00;
    localparam logic [15:0] RST_COUNT   = 16'h0000;
endpackage : acm_pkg

// ==== src/acm_evt_if.sv ====
// Interface carrying event strobes and clears between the bank and its counters
`timescale 1ns/1ps
interface acm_evt_if;
    logic       sym_err;
    logic       hec_err;
    logic       rx_cell;
    logic       tx_cell;
    logic       sw_reset;
    logic [3:0] sel;
    logic [15:0] count;
    modport bank (output sym_err, output hec_err, output rx_cell, output tx_cell,
                  output sw_reset, output sel, input count);
    modport cnt  (input sym_err, input hec_err, input rx_cell, input tx_cell,
                  input sw_reset, input sel, output count);
endinterface : acm_evt_if

// ==== src/acm_counters.sv ====
// Four sixteen-bit event counters with selected readout
`timescale 1ns/1ps
module acm_counters #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // Events and readout
    acm_evt_if.cnt    evt
);
    if (CNT_W != 16) begin : g_bad_width
        $error("acm_counters: CNT_W must be 16");
    end

    logic [CNT_W-1:0] cnt_reg [acm_pkg::SEL_WIDTH];
    logic [acm_pkg::SEL_WIDTH-1:0] inc;

    assign inc = {evt.sym_err, evt.tx_cell, evt.rx_cell & ~evt.hec_err, evt.hec_err};

    // ****************************************
    // Counting
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < acm_pkg::SEL_WIDTH; i++) begin
                cnt_reg[i] <= acm_pkg::RST_COUNT;
            end
        end else if (evt.sw_reset) begin
            for (int i = 0; i < acm_pkg::SEL_WIDTH; i++) begin
                cnt_reg[i] <= acm_pkg::RST_COUNT;
            end
        end else begin
            for (int i = 0; i < acm_pkg::SEL_WIDTH; i++) begin
                if (inc[i]) begin
                    cnt_reg[i] <= cnt_reg[i] + 16'h0001;
                end
            end
        end
    end

    // ****************************************
    // Selected readout
    // ****************************************
    always_comb begin
        evt.count = 16'h0000;
        for (int i = 0; i < acm_pkg::SEL_WIDTH; i++) begin
            if (evt.sel[i]) begin
                evt.count = evt.count | cnt_reg[i];
            end
        end
    end
endmodule : acm_counters

// ==== src/acm_regs.sv ====
// Counter select, interrupt mask and extended control register bank
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - Low-byte register reads bits 7:0 of the selected counter; resets zero.
// - High-byte register reads bits 15:8 of the selected sixteen-bit counter.
// - Write-only select: bit3 symbol errors, bit0 header checksum errors.
// - Selected receive cell counter never counts checksum-errored cells.
// - Six read/write mask bits, one per interrupt source; bits 7:6 reserved.
// - Mask one blocks a status bit from the pin; zero passes; reset zero.
// - Writing one to control bit 7 resets the device, then clears itself.
// - Control bit 6 picks transmit clock: zero local oscillator, one recovered.
// - Control bits 4:0 hold the five-bit cell-bus port address, reset zero.
// - Receive overflow status latches on a data push while buffer full, holds until cleared.
// - Undefined received symbol sets symbol-error status and bumps its count.
module acm_regs (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // Register port
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Receive and transmit events
    input  wire logic       rx_buf_full_in,
    input  wire logic       rx_data_push_in,
    input  wire logic       sym_invalid_in,
    input  wire logic       hec_err_in,
    input  wire logic       rx_cell_in,
    input  wire logic       tx_cell_in,
    input  wire logic       short_cell_in,
    input  wire logic       tx_parity_err_in,
    input  wire logic       sig_change_in,
    // Cell-bus address
    input  wire logic [4:0] cell_bus_addr_in,
    // Control outputs
    output logic            irq_out,
    output logic            sw_reset_out,
    output logic            loop_clk_sel_out,
    output logic      [4:0] port_addr_out,
    output logic            cell_bus_sel_out
);
    logic [7:0]                      rdata_reg;
    logic [acm_pkg::SEL_WIDTH-1:0]   sel_reg;
    logic [acm_pkg::SRC_WIDTH-1:0]   mask_reg;
    logic [acm_pkg::SRC_WIDTH-1:0]   stat_reg;
    logic [acm_pkg::SRC_WIDTH-1:0]   stat_set;
    logic                            loop_reg;
    logic                            rsvd5_reg;
    logic [acm_pkg::PORT_ADDR_W-1:0] paddr_reg;
    logic                            swrst_reg;
    logic                            irq_reg;
    logic                            csel_reg;
    logic                            stat_clr;

    acm_evt_if evt ();

    assign evt.sym_err  = sym_invalid_in;
    assign evt.hec_err  = hec_err_in;
    assign evt.rx_cell  = rx_cell_in;
    assign evt.tx_cell  = tx_cell_in;
    assign evt.sw_reset = swrst_reg;
    assign evt.sel      = sel_reg;

    acm_counters #(
        .CNT_W (16)
    ) u_counters (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .evt     (evt)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    // ****************************************
    // Counter select
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_reg <= acm_pkg::RST_CNT_SEL[acm_pkg::SEL_WIDTH-1:0];
        end else if (swrst_reg) begin
            sel_reg <= acm_pkg::RST_CNT_SEL[acm_pkg::SEL_WIDTH-1:0];
        end else if (wr_in && hit(addr_in, acm_pkg::OFF_CNT_SEL)) begin
            sel_reg <= wdata_in[acm_pkg::SEL_WIDTH-1:0];
        end
    end

    // ****************************************
    // Interrupt mask
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_reg <= acm_pkg::RST_INT_MASK[acm_pkg::SRC_WIDTH-1:0];
        end else if (swrst_reg) begin
            mask_reg <= acm_pkg::RST_INT_MASK[acm_pkg::SRC_WIDTH-1:0];
        end else if (wr_in && hit(addr_in, acm_pkg::OFF_INT_MASK)) begin
            mask_reg <= wdata_in[acm_pkg::SRC_WIDTH-1:0];
        end
    end

    // ****************************************
    // Extended control
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            loop_reg  <= acm_pkg::RST_EXT_CTRL[acm_pkg::CTRL_LOOP_CLK];
            rsvd5_reg <= acm_pkg::RST_EXT_CTRL[acm_pkg::CTRL_RSVD5];
            paddr_reg <= acm_pkg::RST_EXT_CTRL[acm_pkg::PORT_ADDR_W-1:0];
        end else if (swrst_reg) begin
            loop_reg  <= acm_pkg::RST_EXT_CTRL[acm_pkg::CTRL_LOOP_CLK];
            rsvd5_reg <= acm_pkg::RST_EXT_CTRL[acm_pkg::CTRL_RSVD5];
            paddr_reg <= acm_pkg::RST_EXT_CTRL[acm_pkg::PORT_ADDR_W-1:0];
        end else if (wr_in && hit(addr_in, acm_pkg::OFF_EXT_CTRL)) begin
            loop_reg  <= wdata_in[acm_pkg::CTRL_LOOP_CLK];
            rsvd5_reg <= wdata_in[acm_pkg::CTRL_RSVD5];
            paddr_reg <= wdata_in[acm_pkg::PORT_ADDR_W-1:0];
        end
    end

    // Software reset pulse, one cycle, self-clearing
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            swrst_reg <= 1'b0;
        end else begin
            swrst_reg <= wr_in && hit(addr_in, acm_pkg::OFF_EXT_CTRL) && wdata_in[acm_pkg::CTRL_SW_RESET];
        end
    end

    // ****************************************
    // Latched status
    // ****************************************
    assign stat_set[acm_pkg::SRC_RX_OVF]   = rx_buf_full_in & rx_data_push_in;
    assign stat_set[acm_pkg::SRC_SYM_ERR]  = sym_invalid_in;
    assign stat_set[acm_pkg::SRC_SIG_CHG]  = sig_change_in;
    assign stat_set[acm_pkg::SRC_TX_PAR]   = tx_parity_err_in;
    assign stat_set[acm_pkg::SRC_SHORT]    = short_cell_in;
    assign stat_set[acm_pkg::SRC_HEC_CELL] = hec_err_in;
    assign stat_clr = rd_in && hit(addr_in, acm_pkg::OFF_INT_STAT);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stat_reg <= '0;
        end else if (swrst_reg) begin
            stat_reg <= '0;
        end else if (stat_clr) begin
            stat_reg <= stat_set;
        end else begin
            stat_reg <= stat_reg | stat_set;
        end
    end

    // ****************************************
    // Interrupt pin and cell-bus select
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(stat_reg & ~mask_reg);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            csel_reg <= 1'b0;
        end else begin
            csel_reg <= cell_bus_addr_in == paddr_reg;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_reg <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                acm_pkg::OFF_CNT_LOW:  rdata_reg <= evt.count[7:0];
                acm_pkg::OFF_CNT_HIGH: rdata_reg <= evt.count[15:8];
                acm_pkg::OFF_INT_MASK: rdata_reg <= {2'b00, mask_reg};
                acm_pkg::OFF_EXT_CTRL: rdata_reg <= {1'b0, loop_reg, rsvd5_reg, paddr_reg};
                acm_pkg::OFF_INT_STAT: rdata_reg <= {2'b00, stat_reg};
                default:               rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign rdata_out        = rdata_reg;
    assign irq_out          = irq_reg;
    assign sw_reset_out     = swrst_reg;
    assign loop_clk_sel_out = loop_reg;
    assign port_addr_out    = paddr_reg;
    assign cell_bus_sel_out = csel_reg;
endmodule : acm_regs

// ==== test/acm_regs_properties.sv ====
// Checker of register bank port behaviour
`timescale 1ns/1ps
module acm_regs_props (
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       rstn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // Events
    input wire logic       rx_buf_full_in,
    input wire logic       rx_data_push_in,
    input wire logic       sym_invalid_in,
    input wire logic       hec_err_in,
    input wire logic       short_cell_in,
    input wire logic       tx_parity_err_in,
    input wire logic       sig_change_in,
    input wire logic [4:0] cell_bus_addr_in,
    // Outputs
    input wire logic       irq_out,
    input wire logic       sw_reset_out,
    input wire logic       loop_clk_sel_out,
    input wire logic [4:0] port_addr_out,
    input wire logic       cell_bus_sel_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic ev;
    logic mw;
    logic cw;
    logic sr;
    assign ev = (rx_buf_full_in & rx_data_push_in) | sym_invalid_in | hec_err_in | short_cell_in
              | tx_parity_err_in | sig_change_in;
    assign mw = wr_in & (addr_in == acm_pkg::OFF_INT_MASK);
    assign cw = wr_in & (addr_in == acm_pkg::OFF_EXT_CTRL);
    assign sr = rd_in & (addr_in == acm_pkg::OFF_INT_STAT);
    AST_SEL_READ_ZERO: assert property ($past(rd_in) && $past(addr_in) == acm_pkg::OFF_CNT_SEL
        |-> rdata_out == 8'h00) else $error("select register read not zero");
    AST_SWRST_PULSE: assert property (cw && wdata_in[7] |=> sw_reset_out)
        else $error("software reset pulse missing");
    AST_SWRST_CLEAR: assert property (sw_reset_out && !(cw && wdata_in[7]) |=> !sw_reset_out)
        else $error("software reset not self clearing");
    AST_LOOP_CLK: assert property (cw && !wdata_in[7] && !sw_reset_out
        |=> loop_clk_sel_out == $past(wdata_in[6])) else $error("line clock choice wrong");
    AST_PORT_ADDR: assert property (cw && !wdata_in[7] && !sw_reset_out
        |=> port_addr_out == $past(wdata_in[4:0])) else $error("port address wrong");
    AST_CELL_SEL: assert property ($past(rstn_in) && !$past(sw_reset_out)
        |-> cell_bus_sel_out == ($past(cell_bus_addr_in) == $past(port_addr_out))) else $error("cell bus select wrong");
    AST_IRQ_RISE: assert property ($rose(irq_out)
        |-> $past(ev) || $past(ev, 2) || $past(mw) || $past(mw, 2)) else $error("interrupt rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(mw) || $past(mw, 2) || $past(sr)
        || $past(sr, 2) || $past(sw_reset_out) || $past(sw_reset_out, 2)) else $error("interrupt fell without cause");
    cover property (sw_reset_out);
    cover property ($rose(irq_out));
    cover property (cell_bus_sel_out);
endmodule : acm_regs_props
bind acm_regs acm_regs_props u_props (.clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .rx_buf_full_in, .rx_data_push_in, .sym_invalid_in, .hec_err_in, .short_cell_in, .tx_parity_err_in,
    .sig_change_in, .cell_bus_addr_in, .irq_out, .sw_reset_out, .loop_clk_sel_out, .port_addr_out,
    .cell_bus_sel_out);

// ==== test/acm_host.sv ====
// Host model driving the register port
`timescale 1ns/1ps
module acm_host (
    // Clock
    input  wire logic       clk_in,
    // Register port
    output logic      [7:0] addr_out = 8'h00,
    output logic      [7:0] wdata_out = 8'h00,
    output logic            wr_out = 1'b0,
    output logic            rd_out = 1'b0
);
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~d;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
    endtask : rd_reg
    task automatic sel_cnt(input int i);
        wr_reg(acm_pkg::OFF_CNT_SEL, 8'h01 << i);
    endtask : sel_cnt
endmodule : acm_host

// ==== test/tb_top.sv ====
// Self-checking bench of the register bank
`timescale 1ns/1ps
module tb_top;
    logic        clk_in = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        wr;
    logic        rd;
    logic        full = 1'b0, push = 1'b0, sym = 1'b0, hec = 1'b0, rxc = 1'b0;
    logic        txc = 1'b0, shc = 1'b0, par = 1'b0, sig = 1'b0;
    logic [4:0]  cba = 5'h00;
    logic [4:0]  cba_q;
    logic [4:0]  pa = 5'h00;
    logic [4:0]  padr;
    logic        irq, swr, lck, cbs, rd_q;
    logic [31:0] r = 32'hB8AC;
    logic [31:0] r2 = 32'hB8AC;
    logic [15:0] cnt [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [7:0]  exp_q [$];
    int          n_fail = 0;
    int          comparisons = 0;
    always #5 clk_in = ~clk_in;
    acm_host u_host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    acm_regs u_dut (.clk_in(clk_in), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .rx_buf_full_in(full), .rx_data_push_in(push), .sym_invalid_in(sym), .hec_err_in(hec),
        .rx_cell_in(rxc), .tx_cell_in(txc), .short_cell_in(shc), .tx_parity_err_in(par), .sig_change_in(sig),
        .cell_bus_addr_in(cba), .irq_out(irq), .sw_reset_out(swr), .loop_clk_sel_out(lck),
        .port_addr_out(padr), .cell_bus_sel_out(cbs));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd_reg(a);
    endtask : rdx
    task automatic pause(input int n, input string nm, input logic [15:0] seen_exp);
        repeat (n) @(posedge clk_in);
        #1 chk(nm, 16'(irq), seen_exp);
    endtask : pause
    task automatic test_done();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    always @(posedge clk_in) begin
        r2 <= xs(r2);
        cba <= r2[5] ? pa : r2[4:0];
        cba_q <= cba;
        rd_q <= rd;
    end
    always @(negedge clk_in) begin
        if (rd_q === 1'b1) begin
            if (exp_q.size() == 0) chk("queue", 16'h0001, 16'h0000);
            else chk("rdata", 16'(rdata), 16'(exp_q.pop_front()));
        end
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        rstn <= 1'b1;
        for (int a = 4; a <= 8; a++) rdx(8'(a), 8'h00);
        repeat (600) begin
            @(posedge clk_in);
            r = xs(r);
            {sym, txc, rxc, hec} <= r[3:0];
            cnt[0] += 16'(r[0]);
            cnt[1] += 16'(r[1] & ~r[0]);
            cnt[2] += 16'(r[2]);
            cnt[3] += 16'(r[3]);
        end
        @(posedge clk_in);
        {sym, txc, rxc, hec} <= 4'h0;
        for (int i = 0; i < 4; i++) begin
            u_host.sel_cnt(i);
            rdx(acm_pkg::OFF_CNT_LOW, cnt[i][7:0]);
            rdx(acm_pkg::OFF_CNT_HIGH, cnt[i][15:8]);
        end
        rdx(acm_pkg::OFF_CNT_SEL, 8'h00);
        u_host.wr_reg(acm_pkg::OFF_INT_MASK, 8'hFF);
        rdx(acm_pkg::OFF_INT_STAT, 8'h22);
        full <= 1'b1;
        rdx(acm_pkg::OFF_INT_STAT, 8'h00);
        full <= 1'b0;
        @(posedge clk_in);
        {full, push, sym, hec, shc, par, sig} <= 7'h7F;
        @(posedge clk_in);
        {full, push, sym, hec, shc, par, sig} <= 7'h00;
        pause(3, "irq_masked", 16'h0000);
        rdx(acm_pkg::OFF_INT_MASK, 8'h3F);
        u_host.wr_reg(acm_pkg::OFF_INT_MASK, 8'h3E);
        pause(8, "irq_held", 16'h0001);
        rdx(acm_pkg::OFF_INT_STAT, 8'h3F);
        pause(3, "irq_clear", 16'h0000);
        r = xs(r);
        u_host.wr_reg(acm_pkg::OFF_EXT_CTRL, {1'b0, r[6:0]});
        rdx(acm_pkg::OFF_EXT_CTRL, {1'b0, r[6:0]});
        #1 chk("loop_clk", 16'(lck), 16'(r[6]));
        chk("port_addr", 16'(padr), 16'(r[4:0]));
        pa = r[4:0];
        repeat (40) begin
            @(negedge clk_in);
            chk("cell_sel", 16'(cbs), 16'(cba_q == r[4:0]));
        end
        u_host.wr_reg(8'h20, 8'hFF);
        rdx(8'h20, 8'h00);
        u_host.wr_reg(acm_pkg::OFF_EXT_CTRL, 8'h80);
        #1 chk("sw_reset", 16'(swr), 16'h0001);
        rdx(acm_pkg::OFF_EXT_CTRL, 8'h00);
        #1 chk("sw_reset_end", 16'(swr), 16'h0000);
        rdx(acm_pkg::OFF_INT_MASK, 8'h00);
        repeat (3) @(posedge clk_in);
        test_done();
    end
endmodule : tb_top
